// ===== shared/pot_cmd_consts.vh
// Constants for the dual pot serial command decoder
`ifndef POT_CMD_CONSTS_VH
`define POT_CMD_CONSTS_VH
`define DEV_ID_BITS       6'h14
`define OP_GLOBAL_RECALL  4'h1
`define OP_GLOBAL_SAVE    4'h8
`define OP_SINGLE_SAVE    4'he
`define OP_SINGLE_RECALL  4'hd
`define OP_STEP           4'h2
`define BITS_PER_BYTE     4'h8
`define WIPER_MAX         6'h3f
`define WIPER_MIN         6'h00
`define WIPER_RESET       6'h00
`define NV_WRITE_TIME_NS  5000000
`define CLK_PERIOD_NS     4
`endif

// ===== hdl/pot_edge_sync.v
// Two-stage synchroniser with rise and fall detection
`timescale 1ns/1ps
`default_nettype none
module pot_edge_sync #(
  parameter IDLE_LEVEL = 1'b0
) (
  input  wire i_ref_clk,
  input  wire i_rst,
  input  wire i_async,
  output reg  o_level,
  output wire o_rise,
  output wire o_fall
);
  reg meta;
  reg sync;
  // First stage feeds only the second stage
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      // Reset to the pin's idle level so no false edge follows reset
      meta    <= IDLE_LEVEL;
      sync    <= IDLE_LEVEL;
      o_level <= IDLE_LEVEL;
    end else begin
      meta    <= i_async;
      sync    <= meta;
      o_level <= sync;
    end
  end
  assign o_rise = sync & ~o_level;
  assign o_fall = ~sync & o_level;
endmodule // pot_edge_sync
`default_nettype wire

// ===== hdl/pot_cmd_decoder.v
// Serial command decoder for a dual 64-tap pot
//
// Functional notes
// (R1) Global recall copies chosen slot into both wipers
// (R2) Global save stores both wipers, high-voltage cycle
// (R3) Single save stores one wiper, high-voltage cycle
// (R4) Single recall loads one pot's chosen slot
// (R5) Step command shifts direction bits until deselect
// (R6) Nonvolatile write starts only after chip select rises
// (R7) High bit steps up, low bit steps down
// (R8) Busy flag high throughout nonvolatile write
// (R9) Nonvolatile write lasts at least the write time
// (R10) Strap mismatch frame changes nothing
`include "pot_cmd_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module pot_cmd_decoder #(
  parameter NV_WRITE_CYCLES = `NV_WRITE_TIME_NS / `CLK_PERIOD_NS
) (
  input  wire       i_ref_clk,
  input  wire       i_rst,
  input  wire       i_cs_n,
  input  wire       i_sck,
  input  wire       i_si,
  input  wire       i_addr_strap_hi,
  input  wire       i_addr_strap_lo,
  output reg  [5:0] o_wiper0,
  output reg  [5:0] o_wiper1,
  output reg        o_write_in_progress_flag
);
  wire cs_lvl, cs_rise, cs_fall;
  // Only the serial clock's rising edge is used (mode 0,0)
  wire sck_rise;
  wire si_lvl;
  wire strap_hi, strap_lo;
  reg  strap_hi_m, strap_hi_s, strap_lo_m, strap_lo_s;

  // Chip select idles high; clock and data idle low
  pot_edge_sync #(.IDLE_LEVEL(1'b1)) u_cs (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_async(i_cs_n),
                      .o_level(cs_lvl), .o_rise(cs_rise), .o_fall(cs_fall));
  pot_edge_sync #(.IDLE_LEVEL(1'b0)) u_sck (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_async(i_sck),
                       .o_level(), .o_rise(sck_rise), .o_fall());
  pot_edge_sync u_si (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_async(i_si),
                      .o_level(si_lvl), .o_rise(), .o_fall());

  // Strap pins are slow but still cross domains
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      strap_hi_m <= 1'b0;
      strap_hi_s <= 1'b0;
      strap_lo_m <= 1'b0;
      strap_lo_s <= 1'b0;
    end else begin
      strap_hi_m <= i_addr_strap_hi;
      strap_hi_s <= strap_hi_m;
      strap_lo_m <= i_addr_strap_lo;
      strap_lo_s <= strap_lo_m;
    end
  end
  assign strap_hi = strap_hi_s;
  assign strap_lo = strap_lo_s;

  // Saturating step toward either terminal
  function [5:0] step_wiper;
    input [5:0] cur;
    input       up;
    begin
      if (up)
        step_wiper = (cur == `WIPER_MAX) ? cur : cur + 6'h01;
      else
        step_wiper = (cur == `WIPER_MIN) ? cur : cur - 6'h01;
    end
  endfunction

  localparam ST_IDLE  = 3'h0;
  localparam ST_ADDR  = 3'h1;
  localparam ST_INSTR = 3'h2;
  localparam ST_STEP  = 3'h3;
  localparam ST_DONE  = 3'h4;
  localparam ST_SKIP  = 3'h5;

  reg [2:0]  state;
  reg [3:0]  bit_cnt;
  reg [7:0]  shift;
  reg [5:0]  saved0 [0:3];
  reg [5:0]  saved1 [0:3];
  reg        pend_save;
  reg        pend_both;
  reg        pend_pot;
  reg [1:0]  pend_slot;
  reg        step_pot;
  reg [31:0] nv_cnt;
  reg        nv_both;
  reg        nv_pot;
  reg [1:0]  nv_slot;
  reg [5:0]  nv_data0;
  reg [5:0]  nv_data1;
  integer    k;

  wire [7:0] next_shift = {shift[6:0], si_lvl};
  wire [3:0] op   = next_shift[7:4];
  wire [1:0] slot = next_shift[3:2];
  wire       pot  = next_shift[0];

  // Frame decode on synchronised clock edges; mode 0,0 samples on rise
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      state     <= ST_IDLE;
      bit_cnt   <= 4'h0;
      shift     <= 8'h00;
      pend_save <= 1'b0;
      pend_both <= 1'b0;
      pend_pot  <= 1'b0;
      pend_slot <= 2'h0;
      step_pot  <= 1'b0;
      o_wiper0  <= `WIPER_RESET;
      o_wiper1  <= `WIPER_RESET;
      o_write_in_progress_flag <= 1'b0;
      nv_cnt    <= 32'h0;
      nv_both   <= 1'b0;
      nv_pot    <= 1'b0;
      nv_slot   <= 2'h0;
      nv_data0  <= 6'h00;
      nv_data1  <= 6'h00;
      for (k = 0; k < 4; k = k + 1) begin
        saved0[k] <= `WIPER_RESET;
        saved1[k] <= `WIPER_RESET;
      end
    end else begin
      if (cs_fall) begin
        state   <= ST_ADDR;
        bit_cnt <= 4'h0;
        pend_save <= 1'b0;
      end else if (cs_rise) begin
        state <= ST_IDLE;
        // Start the high-voltage cycle only at deselect
        if (pend_save && !o_write_in_progress_flag) begin // see (R6)
          o_write_in_progress_flag <= 1'b1; // see (R8)
          nv_cnt   <= 32'h0;
          nv_both  <= pend_both;
          nv_pot   <= pend_pot;
          nv_slot  <= pend_slot;
          // Data captured here, so later steps cannot alter the save
          nv_data0 <= o_wiper0;
          nv_data1 <= o_wiper1;
        end
        pend_save <= 1'b0;
      end else if (!cs_lvl && sck_rise) begin
        shift <= next_shift;
        case (state)
          ST_ADDR: begin
            bit_cnt <= bit_cnt + 4'h1;
            if (bit_cnt == `BITS_PER_BYTE - 4'h1) begin
              bit_cnt <= 4'h0;
              // Wrong id or straps: skip the rest of the frame
              if (next_shift[7:2] == `DEV_ID_BITS &&
                  next_shift[1] == strap_hi && next_shift[0] == strap_lo)
                state <= ST_INSTR;
              else
                state <= ST_SKIP; // see (R10)
            end
          end
          ST_INSTR: begin
            bit_cnt <= bit_cnt + 4'h1;
            if (bit_cnt == `BITS_PER_BYTE - 4'h1) begin
              state <= ST_DONE;
              case (op)
                `OP_GLOBAL_RECALL: begin
                  o_wiper0 <= saved0[slot]; // see (R1)
                  o_wiper1 <= saved1[slot];
                end
                `OP_GLOBAL_SAVE: begin
                  pend_save <= 1'b1; // see (R2)
                  pend_both <= 1'b1;
                  pend_slot <= slot;
                end
                `OP_SINGLE_SAVE: begin
                  pend_save <= 1'b1; // see (R3)
                  pend_both <= 1'b0;
                  pend_pot  <= pot;
                  pend_slot <= slot;
                end
                `OP_SINGLE_RECALL: begin
                  if (pot) // see (R4)
                    o_wiper1 <= saved1[slot];
                  else
                    o_wiper0 <= saved0[slot];
                end
                `OP_STEP: begin
                  // Reserved bits must be zero, else the op is ignored
                  if (next_shift[3:1] == 3'h0) begin
                    state    <= ST_STEP; // see (R5)
                    step_pot <= pot;
                  end
                end
                default: state <= ST_DONE;
              endcase
            end
          end
          ST_STEP: begin
            // Each clock moves one segment; no limit on count
            if (step_pot) // see (R7)
              o_wiper1 <= step_wiper(o_wiper1, si_lvl);
            else
              o_wiper0 <= step_wiper(o_wiper0, si_lvl);
          end
          default: state <= state;
        endcase
      end
      // Nonvolatile write timer; commit at end of the full time
      // A frame ending mid-write must not stall the count
      if (o_write_in_progress_flag) begin
        nv_cnt <= nv_cnt + 32'h1;
        if (nv_cnt >= NV_WRITE_CYCLES - 1) begin // see (R9)
          o_write_in_progress_flag <= 1'b0; // see (R8)
          if (nv_both || !nv_pot)
            saved0[nv_slot] <= nv_data0;
          if (nv_both || nv_pot)
            saved1[nv_slot] <= nv_data1;
        end
      end
    end
  end
endmodule // pot_cmd_decoder
`default_nettype wire

// ===== bench/pot_cmd_decoder_assertions.sv
// Port checks for the pot command decoder
`timescale 1ns/1ps
`default_nettype none
module pot_chk #(parameter int NV_WRITE_CYCLES = 50) (
  input wire logic       i_ref_clk,
  input wire logic       i_rst,
  input wire logic       i_cs_n,
  input wire logic [5:0] o_wiper0,
  input wire logic [5:0] o_wiper1,
  input wire logic       o_write_in_progress_flag
);
  int  hi;
  wire write_in_progress_flag = o_write_in_progress_flag;
  // Length of the current write, so both bounds can be checked
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      hi <= 0;
    end else begin
      hi <= write_in_progress_flag ? hi + 1 : 0;
    end
  end
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  chk_flag_late: assert property ($rose(write_in_progress_flag) |-> $past(i_cs_n, 2) && $past(i_cs_n, 3)) else $error("early");
  chk_frame_no_write: assert property (!i_cs_n [*4] |-> !$rose(write_in_progress_flag)) else $error("write in frame");
  chk_flag_holds: assert property ($rose(write_in_progress_flag) |=> write_in_progress_flag [*8]) else $error("flag dropped");
  chk_write_min_len: assert property ($fell(write_in_progress_flag) |-> hi >= NV_WRITE_CYCLES) else $error("short");
  chk_write_max_len: assert property (write_in_progress_flag |-> hi <= NV_WRITE_CYCLES + 4) else $error("long");
  chk_wiper_in_frame: assert property ($changed({o_wiper0, o_wiper1}) |-> !i_cs_n) else $error("idle move");
  chk_w0_one_step: assert property ($changed(o_wiper0) |=> $stable(o_wiper0) [*8]) else $error("w0 jumps");
  chk_w1_one_step: assert property ($changed(o_wiper1) |=> $stable(o_wiper1) [*8]) else $error("w1 jumps");
  cover property ($rose(write_in_progress_flag));
  cover property ($fell(write_in_progress_flag));
  cover property ($changed(o_wiper0));
  cover property ($changed(o_wiper1));
endmodule // pot_chk
bind pot_cmd_decoder pot_chk #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES)) u_chk (
  .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_cs_n(i_cs_n), .o_wiper0(o_wiper0), .o_wiper1(o_wiper1),
  .o_write_in_progress_flag(o_write_in_progress_flag));
`default_nettype wire

// ===== bench/pot_spi_host.sv
// Serial host model for the pot command decoder
`timescale 1ns/1ps
`default_nettype none
module pot_spi_host (
  input  wire logic i_ref_clk,
  output var logic  o_cs_n = 1'b1,
  output var logic  o_sck = 1'b0,
  output var logic  o_si = 1'b0
);
  // Half of the 80 ns serial period
  task automatic half();
    repeat (10) @(negedge i_ref_clk);
  endtask
  // Two bytes, then n direction bits, MSB first
  task automatic frame(input logic [15:0] w, input int n, input logic [7:0] d);
    o_cs_n = 1'b0;
    for (int i = 0; i < 16 + n; i++) begin
      o_si = (i < 16) ? w[15 - i] : d[23 - i];
      half();
      o_sck = 1'b1;
      half();
      o_sck = 1'b0;
    end
    half();
    o_si = ~o_si; // Last bit inverted before deselect, no stale bit
    o_cs_n = 1'b1;
    half();
  endtask
endmodule // pot_spi_host
`default_nettype wire

// ===== bench/tb.sv
// Self-checking bench for the pot command decoder
`include "pot_cmd_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int NV = 50;
  logic       i_ref_clk, i_rst, cs_n, sck, si, write_in_progress_flag;
  logic [5:0] w0, w1;
  int         error_cnt = 0;
  int         checks = 0;
  pot_spi_host host (.i_ref_clk(i_ref_clk), .o_cs_n(cs_n), .o_sck(sck), .o_si(si));
  pot_cmd_decoder #(.NV_WRITE_CYCLES(NV)) dut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_cs_n(cs_n), .i_sck(sck),
    .i_si(si), .i_addr_strap_hi(1'b1), .i_addr_strap_lo(1'b0), .o_wiper0(w0), .o_wiper1(w1),
    .o_write_in_progress_flag(write_in_progress_flag));
  // Reference clock
  initial begin
    i_ref_clk = 1'b0;
    forever #2 i_ref_clk = ~i_ref_clk;
  end
  task automatic cmp(input logic [12:0] got, input logic [12:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Frame, then compare {w0, w1, flag}; a write is timed while it runs
  task automatic t(input logic [1:0] a, input logic [7:0] ins, input int n, input logic [7:0] d, input logic [12:0] e);
    int k;
    k = 0;
    host.frame({`DEV_ID_BITS, a, ins}, n, d);
    cmp({w0, w1, write_in_progress_flag}, e);
    while (write_in_progress_flag === 1'b1 && k < 2 * NV) begin
      @(negedge i_ref_clk);
      k++;
    end
    if (e[0])
      cmp(13'(k >= NV - 12 && k <= NV), 13'h0001);
  endtask
  task automatic give_verdict();
    $display("%0d checks, %0d errors", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Cuts a hang short
  initial begin
    #100000;
    error_cnt++;
    give_verdict();
  end
  // Straps read 2'h2; wrong-strap frames use 2'h1
  initial begin
    i_rst = 1'b1;
    repeat (3) @(negedge i_ref_clk);
    i_rst = 1'b0;
    repeat (4) @(negedge i_ref_clk);
    cmp({w0, w1, write_in_progress_flag}, 13'h0000);
    t(2'h2, {`OP_STEP, 4'h0}, 3, 8'he0, 13'h0180);
    t(2'h2, {`OP_SINGLE_SAVE, 4'h8}, 0, 8'h00, 13'h0181);
    t(2'h2, {`OP_STEP, 4'h0}, 5, 8'h00, 13'h0000);
    t(2'h2, {`OP_SINGLE_RECALL, 4'h8}, 0, 8'h00, 13'h0180);
    t(2'h2, {`OP_GLOBAL_SAVE, 4'h4}, 0, 8'h00, 13'h0181);
    t(2'h2, {`OP_STEP, 4'h1}, 8, 8'hff, 13'h0190);
    t(2'h2, {`OP_GLOBAL_RECALL, 4'h4}, 0, 8'h00, 13'h0180);
    // Pot 1 single save to slot 3 must leave pot 0's slot 3 alone
    t(2'h2, {`OP_STEP, 4'h1}, 2, 8'hc0, 13'h0184);
    t(2'h2, {`OP_SINGLE_SAVE, 4'hd}, 0, 8'h00, 13'h0185);
    t(2'h2, {`OP_GLOBAL_RECALL, 4'hc}, 0, 8'h00, 13'h0004);
    t(2'h2, {`OP_SINGLE_RECALL, 4'h5}, 0, 8'h00, 13'h0000);
    t(2'h1, {`OP_STEP, 4'h0}, 4, 8'hf0, 13'h0000);
    t(2'h1, {`OP_GLOBAL_SAVE, 4'h4}, 0, 8'h00, 13'h0000);
    give_verdict();
  end
endmodule // tb
`default_nettype wire
